/* File: bench/lsadc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lsadc_host_model (
  // clock
  input  wire logic clk,
  // bus wires
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drv
);
  logic       ack_seen;
  logic [7:0] rd_byte;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    ack_seen = 1'b1;
    rd_byte = 8'h00;
  end
  task automatic waitc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // bus idle on entry: both lines high
  task automatic start_c;
    sda_drv = 1'b0;
    waitc(8);
    scl = 1'b0;
  endtask
  task automatic stop_c;
    waitc(4);
    sda_drv = 1'b0;
    waitc(4);
    scl = 1'b1;
    waitc(8);
    sda_drv = 1'b1;
    waitc(8);
  endtask
  // data moves mid-low, sampled at the end of the high phase
  task automatic bit_c(input logic b, output logic s);
    waitc(4);
    sda_drv = b;
    waitc(4);
    scl = 1'b1;
    waitc(8);
    s = sda_line;
    scl = 1'b0;
  endtask
  task automatic put_byte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_c(d[i], s);
    bit_c(1'b1, ack_seen);
  endtask
  task automatic get_byte;
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, s);
      rd_byte[i] = s;
    end
    bit_c(1'b1, s);
  endtask
  task automatic access(input logic [7:0] p, input logic [7:0] d, input int kind);
    start_c;
    put_byte(8'h88);
    put_byte(p);
    if (kind == 1) put_byte(d);
    stop_c;
    if (kind == 2) begin
      start_c;
      put_byte(8'h89);
      get_byte;
      stop_c;
    end
  endtask
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        osc_clk = 1'b0;
  logic        charge_pulse = 1'b0;
  logic        scl, sda_drv, sda_out, sda_oe, converter_reset, converter_power_down;
  logic        first_diode_select, second_diode_select, osc_half_speed, int_n;
  logic [15:0] full_scale_span;
  wire logic   sda_line;
  int          n_fail = 0;
  int          total_checks = 0;
  int          cycles = 0;
  // open drain line with pull-up
  assign sda_line = sda_drv & (sda_out | ~sda_oe);
  lsadc_core #(.DATA_W(16)) u_lsadc_core (
    .clk(clk), .resetn(resetn), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .osc_clk(osc_clk), .charge_pulse(charge_pulse),
    .converter_reset(converter_reset), .converter_power_down(converter_power_down),
    .first_diode_select(first_diode_select), .second_diode_select(second_diode_select),
    .osc_half_speed(osc_half_speed), .full_scale_span(full_scale_span), .int_n(int_n));
  lsadc_host_model u_lsadc_host_model (.clk(clk), .sda_line(sda_line), .scl(scl),
    .sda_drv(sda_drv));
  always #50 clk = ~clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks=%0d failures=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    u_lsadc_host_model.access(p, d, 1);
  endtask
  task automatic strobe(input logic [7:0] p);
    u_lsadc_host_model.access(p, 8'h00, 0);
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] b);
    u_lsadc_host_model.access(p, 8'h00, 2);
    b = u_lsadc_host_model.rd_byte;
  endtask
  // n oscillator periods of 800 ns, the first q carrying a charge quantum
  task automatic pulse_osc(input int n, input int q);
    for (int i = 0; i < n; i++) begin
      osc_clk = 1'b1;
      charge_pulse = (i < q);
      repeat (4) @(negedge clk);
      osc_clk = 1'b0;
      charge_pulse = 1'b0;
      repeat (4) @(negedge clk);
    end
    repeat (8) @(negedge clk);
  endtask
  task automatic t_reset;
    logic [7:0] b;
    check(int_n, 1'b1);
    check(full_scale_span, 16'h03cd);
    check(sda_out, 1'b0);
    rd(8'h02, b);
    check(b, 8'hff);
    rd(8'h03, b);
    check(b, 8'h00);
    rd(8'h00, b);
    check(b, 8'h00);
    check(u_lsadc_host_model.ack_seen, 1'b0);
    u_lsadc_host_model.start_c;
    u_lsadc_host_model.put_byte(8'h90);
    u_lsadc_host_model.stop_c;
    check(u_lsadc_host_model.ack_seen, 1'b1);
  endtask
  task automatic t_internal;
    logic [7:0] b;
    wr(8'h00, 8'h8f);
    check(converter_reset, 1'b1);
    wr(8'h00, 8'h87);
    check({first_diode_select, second_diode_select}, 2'b01);
    wr(8'h00, 8'h83);
    check({converter_reset, first_diode_select}, 2'b01);
    pulse_osc(15, 5);
    rd(8'h04, b);
    check(b, 8'h00);
    pulse_osc(1, 0);
    rd(8'h04, b);
    check(b, 8'h05);
    rd(8'h05, b);
    check(b, 8'h00);
    wr(8'h00, 8'h82);
    pulse_osc(255, 2);
    rd(8'h04, b);
    check(b, 8'h05);
    pulse_osc(1, 0);
    rd(8'h04, b);
    check(b, 8'h02);
    wr(8'h00, 8'h83);
  endtask
  task automatic t_irq;
    logic [7:0] b;
    wr(8'h03, 8'h01);
    rd(8'h03, b);
    check(b, 8'h01);
    wr(8'h01, 8'h01);
    repeat (3) pulse_osc(16, 5);
    check(int_n, 1'b1);
    pulse_osc(16, 5);
    check(int_n, 1'b0);
    rd(8'h01, b);
    check(b, 8'h21);
    wr(8'h01, 8'h01);
    check(int_n, 1'b1);
    wr(8'h01, 8'h00);
    pulse_osc(16, 5);
    check(int_n, 1'b0);
    strobe(8'h40);
    check(int_n, 1'b1);
    rd(8'h01, b);
    check(b, 8'h00);
    wr(8'h01, 8'h02);
    repeat (6) pulse_osc(16, 5);
    check(int_n, 1'b1);
    pulse_osc(16, 5);
    check(int_n, 1'b0);
    wr(8'h01, 8'h03);
    repeat (7) pulse_osc(16, 5);
    check(int_n, 1'b1);
    pulse_osc(16, 5);
    check(int_n, 1'b0);
    wr(8'h01, 8'h00);
    check(int_n, 1'b1);
    wr(8'h03, 8'h00);
  endtask
  task automatic t_diff;
    logic [7:0] b;
    wr(8'h00, 8'h8b);
    pulse_osc(16, 7);
    pulse_osc(16, 3);
    rd(8'h04, b);
    check(b, 8'h04);
    pulse_osc(16, 3);
    pulse_osc(16, 7);
    rd(8'h05, b);
    check(b, 8'hff);
    check(int_n, 1'b0);
    strobe(8'h40);
  endtask
  task automatic t_external;
    logic [7:0] b;
    wr(8'h00, 8'ha3);
    strobe(8'h80);
    pulse_osc(10, 6);
    strobe(8'h80);
    rd(8'h06, b);
    check(b, 8'h0a);
    rd(8'h07, b);
    check(b, 8'h00);
    rd(8'h04, b);
    check(b, 8'h06);
    pulse_osc(3, 1);
    strobe(8'h80);
    rd(8'h06, b);
    check(b, 8'h03);
  endtask
  task automatic t_gain_power;
    logic [15:0] span [4] = '{16'h03cd, 16'h0f34, 16'h3cd0, 16'hf340};
    logic [7:0]  b;
    for (int g = 0; g < 4; g++) begin
      wr(8'h01, 8'(g << 2));
      check(full_scale_span, span[g]);
      check(osc_half_speed, 1'(g < 2));
    end
    // disable first, then power down in a later write
    wr(8'h00, 8'h03);
    check(converter_reset, 1'b1);
    wr(8'h00, 8'h43);
    check(converter_power_down, 1'b1);
    rd(8'h00, b);
    check(b, 8'h43);
    wr(8'h02, 8'h12);
    rd(8'h02, b);
    check(b, 8'h12);
  endtask
  initial begin
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    repeat (12) @(negedge clk);
    t_reset();
    t_internal();
    t_irq();
    t_diff();
    t_external();
    t_gain_power();
    complete_run();
  end
endmodule
`default_nettype wire

/* File: hdl/lsadc_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lsadc_map.svh"
module lsadc_core #(
  parameter int DATA_W = 16
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // serial bus pins
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // analog front end
  input  wire logic        osc_clk,
  input  wire logic        charge_pulse,
  output logic             converter_reset,
  output logic             converter_power_down,
  output logic             first_diode_select,
  output logic             second_diode_select,
  output logic             osc_half_speed,
  output logic [15:0]      full_scale_span,
  // interrupt
  output logic             int_n
);
  if (DATA_W != 16) begin : g_bad_width
    $error("lsadc_core serves DATA_W of 16 only");
  end

  function automatic logic hit(input logic wr, input logic [2:0] a, input logic [2:0] t);
    hit = wr && (a == t);
  endfunction

  function automatic logic [15:0] last_count(input logic [1:0] w);
    case (w)
      2'h0: last_count = `LSADC_LAST_W0;
      2'h1: last_count = `LSADC_LAST_W1;
      2'h2: last_count = `LSADC_LAST_W2;
      default: last_count = `LSADC_LAST_W3;
    endcase
  endfunction

  function automatic logic [4:0] persist_of(input logic [1:0] p);
    case (p)
      2'h0: persist_of = `LSADC_PERS_0;
      2'h1: persist_of = `LSADC_PERS_1;
      2'h2: persist_of = `LSADC_PERS_2;
      default: persist_of = `LSADC_PERS_3;
    endcase
  endfunction

  function automatic logic [15:0] range_of(input logic [1:0] g);
    case (g)
      2'h0: range_of = `LSADC_RANGE_1;
      2'h1: range_of = `LSADC_RANGE_2;
      2'h2: range_of = `LSADC_RANGE_3;
      default: range_of = `LSADC_RANGE_4;
    endcase
  endfunction

  // reset release
  logic rst_meta_reg, rst_n_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // pin synchronisers: scl, sda, oscillator, charge pulse
  logic [3:0] pin_raw, pin_filt;
  assign pin_raw = {charge_pulse, osc_clk, sda_in, scl};
  for (genvar gi = 0; gi < 4; gi++) begin : g_sync
    localparam logic IDLE_LVL = 1'(gi < 2); // bus lines idle high: no false edge after reset
    logic s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
    // a change is taken only once two late stages agree
    always_comb filt_next = (s2_reg == s3_reg) ? s2_reg : filt_reg;
    always_ff @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
        s1_reg <= IDLE_LVL;
        s2_reg <= IDLE_LVL;
        s3_reg <= IDLE_LVL;
        filt_reg <= IDLE_LVL;
      end else begin
        s1_reg <= pin_raw[gi];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        filt_reg <= filt_next;
      end
    end
    assign pin_filt[gi] = filt_reg;
  end

  lsadc_reg_if rb ();
  lsadc_i2c u_bus (
    .clk    (clk),
    .rst_n  (rst_n_reg),
    .scl    (pin_filt[0]),
    .sda    (pin_filt[1]),
    .sda_oe (sda_oe),
    .rb     (rb.bus)
  );

  // register and integration state
  lsadc_pkg::lsadc_int_st_t ist_reg, ist_next;
  logic [7:0]  cmd_reg, cmd_next, thr_hi_reg, thr_hi_next, thr_lo_reg, thr_lo_next;
  logic [3:0]  ctl_reg, ctl_next;
  logic [15:0] cnt_reg, cnt_next, tmr_reg, tmr_next, tmr_inc;
  logic [15:0] acc_reg, acc_next, acc_inc, acc1_reg, acc1_next;
  logic [15:0] reading_reg, reading_next, timer_lat_reg, timer_lat_next, result;
  logic [15:0] upper_thr, lower_thr, span_next;
  logic [4:0]  pers_reg, pers_next, m_need;
  logic        phase_reg, phase_next, flag_reg, flag_next, int_n_next;
  logic        osc_prev_reg, chg_prev_reg, osc_rise, chg_rise;
  logic        run_ok, ext, phase_end, end_final, outside, clear_req;
  logic        rst_out_next, pd_next, d1_next, d2_next, half_next;
  logic [1:0]  mode;

  assign mode = cmd_reg[`LSADC_CMD_MODE +: 2];
  assign ext = cmd_reg[`LSADC_CMD_EXT];
  assign osc_rise = pin_filt[2] & ~osc_prev_reg;
  assign chg_rise = pin_filt[3] & ~chg_prev_reg;
  assign upper_thr = {thr_hi_reg, 8'h00};
  assign lower_thr = {thr_lo_reg, 8'h00};
  assign m_need = persist_of(ctl_reg[`LSADC_CTL_PERS +: 2]);

  // register writes
  always_comb begin
    cmd_next = cmd_reg;
    ctl_next = ctl_reg;
    thr_hi_next = thr_hi_reg;
    thr_lo_next = thr_lo_reg;
    if (hit(rb.wr, rb.addr, `LSADC_ADDR_CMD)) begin
      cmd_next = rb.wdata;
      cmd_next[`LSADC_CMD_RSVD] = 1'b0;
    end
    if (hit(rb.wr, rb.addr, `LSADC_ADDR_CTL)) begin
      ctl_next = rb.wdata[3:0];
    end
    if (hit(rb.wr, rb.addr, `LSADC_ADDR_THR_HI)) begin
      thr_hi_next = rb.wdata;
    end
    if (hit(rb.wr, rb.addr, `LSADC_ADDR_THR_LO)) begin
      thr_lo_next = rb.wdata;
    end
  end

  // integration engine
  always_comb begin
    run_ok = cmd_reg[`LSADC_CMD_EN] & ~cmd_reg[`LSADC_CMD_PD] & (mode != `LSADC_MODE_NOP);
    ist_next = ist_reg;
    cnt_next = cnt_reg;
    tmr_next = tmr_reg;
    acc_next = acc_reg;
    acc1_next = acc1_reg;
    phase_next = phase_reg;
    reading_next = reading_reg;
    timer_lat_next = timer_lat_reg;
    end_final = 1'b0;
    tmr_inc = tmr_reg + {15'h0000, osc_rise};
    // the charge count saturates instead of wrapping; the timer wraps
    acc_inc = (chg_rise && acc_reg != 16'hffff) ? acc_reg + 16'h0001 : acc_reg;
    result = (mode == `LSADC_MODE_DIFF) ? acc1_reg - acc_inc : acc_inc;
    // internal timing ignores restart strobes
    phase_end = ext ? rb.restart : (osc_rise && cnt_reg == last_count(cmd_reg[1:0]));
    case (ist_reg)
      lsadc_pkg::IS_RESET: begin
        cnt_next = 16'h0000;
        tmr_next = 16'h0000;
        acc_next = 16'h0000;
        phase_next = 1'b0;
        if (run_ok) begin
          ist_next = ext ? lsadc_pkg::IS_WAIT : lsadc_pkg::IS_RUN;
        end
      end
      lsadc_pkg::IS_WAIT: begin
        if (rb.restart) begin
          ist_next = lsadc_pkg::IS_RUN;
        end
      end
      lsadc_pkg::IS_RUN: begin
        cnt_next = cnt_reg + {15'h0000, osc_rise};
        tmr_next = tmr_inc;
        acc_next = acc_inc;
        if (phase_end) begin
          cnt_next = 16'h0000;
          acc_next = 16'h0000;
          if (mode == `LSADC_MODE_DIFF && !phase_reg) begin
            phase_next = 1'b1;
            acc1_next = acc_inc;
          end else begin
            end_final = 1'b1;
            phase_next = 1'b0;
            tmr_next = 16'h0000;
            reading_next = result;
            timer_lat_next = tmr_inc;
          end
        end
      end
      default: ist_next = lsadc_pkg::IS_RESET;
    endcase
    if (!run_ok) begin
      ist_next = lsadc_pkg::IS_RESET;
    end
  end

  // threshold persistence and interrupt
  always_comb begin
    pers_next = pers_reg;
    flag_next = flag_reg;
    outside = (result > upper_thr) || (result < lower_thr);
    clear_req = rb.clr_int ||
                (hit(rb.wr, rb.addr, `LSADC_ADDR_CTL) && !rb.wdata[`LSADC_CTL_FLAG]);
    if (clear_req) begin
      flag_next = 1'b0;
    end
    // a trigger in the clearing cycle wins
    if (end_final && outside) begin
      if (5'(pers_reg + 5'h01) >= m_need) begin
        flag_next = 1'b1;
        pers_next = m_need;
      end else begin
        pers_next = 5'(pers_reg + 5'h01);
      end
    end else if (end_final) begin
      pers_next = 5'h00;
    end
    int_n_next = ~flag_next;
  end

  // pin outputs
  always_comb begin
    rst_out_next = ist_next != lsadc_pkg::IS_RUN;
    pd_next = cmd_reg[`LSADC_CMD_PD];
    d1_next = !rst_out_next && (mode == `LSADC_MODE_D1 ||
              (mode == `LSADC_MODE_DIFF && !phase_next));
    d2_next = !rst_out_next && (mode == `LSADC_MODE_D2 ||
              (mode == `LSADC_MODE_DIFF && phase_next));
    half_next = !ctl_next[`LSADC_CTL_GAIN + 1];
    span_next = range_of(ctl_next[`LSADC_CTL_GAIN +: 2]);
  end

  // register read
  always_comb begin
    case (rb.addr)
      `LSADC_ADDR_CMD: rb.rdata = cmd_reg;
      `LSADC_ADDR_CTL: rb.rdata = {2'h0, flag_reg, 1'b0, ctl_reg};
      `LSADC_ADDR_THR_HI: rb.rdata = thr_hi_reg;
      `LSADC_ADDR_THR_LO: rb.rdata = thr_lo_reg;
      `LSADC_ADDR_RD_LO: rb.rdata = reading_reg[7:0];
      `LSADC_ADDR_RD_HI: rb.rdata = reading_reg[15:8];
      `LSADC_ADDR_TM_LO: rb.rdata = timer_lat_reg[7:0];
      `LSADC_ADDR_TM_HI: rb.rdata = timer_lat_reg[15:8];
      default: rb.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ist_reg <= lsadc_pkg::IS_RESET;
      cmd_reg <= `LSADC_CMD_RST;
      ctl_reg <= `LSADC_CTL_RST;
      thr_hi_reg <= `LSADC_THR_HI_RST;
      thr_lo_reg <= `LSADC_THR_LO_RST;
      cnt_reg <= 16'h0000;
      tmr_reg <= 16'h0000;
      acc_reg <= 16'h0000;
      acc1_reg <= 16'h0000;
      reading_reg <= 16'h0000;
      timer_lat_reg <= 16'h0000;
      pers_reg <= 5'h00;
      phase_reg <= 1'b0;
      flag_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
      chg_prev_reg <= 1'b0;
      int_n <= 1'b1;
      converter_reset <= 1'b1;
      converter_power_down <= 1'b0;
      first_diode_select <= 1'b0;
      second_diode_select <= 1'b0;
      osc_half_speed <= 1'b1;
      full_scale_span <= `LSADC_RANGE_1;
      sda_out <= 1'b0;
    end else begin
      ist_reg <= ist_next;
      cmd_reg <= cmd_next;
      ctl_reg <= ctl_next;
      thr_hi_reg <= thr_hi_next;
      thr_lo_reg <= thr_lo_next;
      cnt_reg <= cnt_next;
      tmr_reg <= tmr_next;
      acc_reg <= acc_next;
      acc1_reg <= acc1_next;
      reading_reg <= reading_next;
      timer_lat_reg <= timer_lat_next;
      pers_reg <= pers_next;
      phase_reg <= phase_next;
      flag_reg <= flag_next;
      osc_prev_reg <= pin_filt[2];
      chg_prev_reg <= pin_filt[3];
      int_n <= int_n_next;
      converter_reset <= rst_out_next;
      converter_power_down <= pd_next;
      first_diode_select <= d1_next;
      second_diode_select <= d2_next;
      osc_half_speed <= half_next;
      full_scale_span <= span_next;
      sda_out <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_reg);

  a_core_held_reset: assert property (
    !cmd_reg[`LSADC_CMD_EN] |=> converter_reset && !first_diode_select && !second_diode_select)
    else $error("core not held in reset");
  a_power_down_out: assert property (
    cmd_reg[`LSADC_CMD_PD] |=> converter_power_down && converter_reset)
    else $error("power-down not applied");
  a_internal_end: assert property (
    ist_reg == lsadc_pkg::IS_RUN && run_ok && !ext && mode != `LSADC_MODE_DIFF && osc_rise
    && cnt_reg == last_count(cmd_reg[1:0]) |=> tmr_reg == 16'h0000
    && timer_lat_reg == 16'($past(tmr_reg) + 16'h0001))
    else $error("internal integration end wrong");
  a_ext_no_end: assert property (
    ist_reg == lsadc_pkg::IS_RUN && ext && !rb.restart |=> $stable(reading_reg))
    else $error("host-timed integration ended without strobe");
  a_flag_persist: assert property (
    end_final && outside && 5'(pers_reg + 5'h01) >= m_need |=> flag_reg ##1 !int_n)
    else $error("interrupt not raised after persistence");
  a_tally_restart: assert property (
    end_final && !outside && !clear_req |=> pers_reg == 5'h00 && $stable(flag_reg))
    else $error("tally not restarted");
  a_clear_int: assert property (
    rb.clr_int && !end_final |=> !flag_reg ##1 int_n)
    else $error("interrupt not cleared");
  a_int_hold: assert property (
    !int_n && !clear_req |=> !int_n)
    else $error("interrupt released without clear");
  a_upper_thr: assert property (
    hit(rb.wr, rb.addr, `LSADC_ADDR_THR_HI) |=> upper_thr == {$past(rb.wdata), 8'h00})
    else $error("upper threshold not formed");
  a_reading_upd: assert property (
    end_final |=> reading_reg == $past(result))
    else $error("reading not refreshed");
endmodule
`default_nettype wire

/* File: hdl/lsadc_i2c.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lsadc_map.svh"
module lsadc_i2c (
  // clock and reset
  input  wire logic    clk,
  input  wire logic    rst_n,
  // filtered bus lines
  input  wire logic    scl,
  input  wire logic    sda,
  output logic         sda_oe,
  // register side
  lsadc_reg_if.bus     rb
);
  lsadc_pkg::lsadc_bus_st_t st_reg, st_next;
  logic [7:0] sh_reg, sh_next, wd_reg, wd_next;
  logic [3:0] bit_reg, bit_next;
  logic [2:0] ptr_reg, ptr_next;
  logic       rw_reg, rw_next, first_reg, first_next, oe_reg, oe_next;
  logic       wr_reg, wr_next, rs_reg, rs_next, ci_reg, ci_next;
  logic       scl_d_reg, sda_d_reg;
  logic       rise, fall, start, stop;

  assign rise  = scl & ~scl_d_reg;
  assign fall  = ~scl & scl_d_reg;
  assign start = scl & scl_d_reg & sda_d_reg & ~sda;
  assign stop  = scl & scl_d_reg & ~sda_d_reg & sda;

  always_comb begin
    st_next = st_reg;
    sh_next = sh_reg;
    wd_next = wd_reg;
    bit_next = bit_reg;
    ptr_next = ptr_reg;
    rw_next = rw_reg;
    first_next = first_reg;
    oe_next = oe_reg;
    wr_next = 1'b0;
    rs_next = 1'b0;
    ci_next = 1'b0;
    if (start) begin
      st_next = lsadc_pkg::BS_ADDR;
      bit_next = 4'h0;
      oe_next = 1'b0;
    end else if (stop) begin
      st_next = lsadc_pkg::BS_IDLE;
      oe_next = 1'b0;
    end else begin
      case (st_reg)
        lsadc_pkg::BS_IDLE: begin
        end
        lsadc_pkg::BS_ADDR, lsadc_pkg::BS_WBYTE: begin
          if (rise && bit_reg != 4'h8) begin
            sh_next = {sh_reg[6:0], sda};
            bit_next = bit_reg + 4'h1;
          end else if (fall && bit_reg == 4'h8) begin
            bit_next = 4'h0;
            if (st_reg == lsadc_pkg::BS_ADDR) begin
              if (sh_reg[7:1] == `LSADC_SLAVE_ADDR) begin
                oe_next = 1'b1;
                rw_next = sh_reg[0];
                first_next = 1'b1;
                st_next = lsadc_pkg::BS_AACK;
              end else begin
                st_next = lsadc_pkg::BS_IDLE;
              end
            end else begin
              oe_next = 1'b1;
              st_next = lsadc_pkg::BS_WACK;
              if (first_reg) begin
                ptr_next = sh_reg[2:0];
                rs_next = sh_reg[`LSADC_PTR_RESTART];
                ci_next = sh_reg[`LSADC_PTR_CLRINT];
                first_next = 1'b0;
              end else begin
                wr_next = 1'b1;
                wd_next = sh_reg;
              end
            end
          end
        end
        lsadc_pkg::BS_AACK: begin
          if (fall && rw_reg) begin
            sh_next = rb.rdata;
            oe_next = ~rb.rdata[7];
            bit_next = 4'h1;
            st_next = lsadc_pkg::BS_RBYTE;
          end else if (fall) begin
            oe_next = 1'b0;
            st_next = lsadc_pkg::BS_WBYTE;
          end
        end
        lsadc_pkg::BS_WACK: begin
          if (fall) begin
            oe_next = 1'b0;
            st_next = lsadc_pkg::BS_WBYTE;
          end
        end
        lsadc_pkg::BS_RBYTE: begin
          if (fall && bit_reg == 4'h8) begin
            oe_next = 1'b0;
            bit_next = 4'h0;
            st_next = lsadc_pkg::BS_RACK;
          end else if (fall) begin
            sh_next = {sh_reg[6:0], 1'b0};
            oe_next = ~sh_reg[6];
            bit_next = bit_reg + 4'h1;
          end
        end
        lsadc_pkg::BS_RACK: begin
          if (rise && sda) begin
            st_next = lsadc_pkg::BS_IDLE;
          end else if (rise) begin
            ptr_next = ptr_reg + 3'h1;
          end else if (fall) begin
            sh_next = rb.rdata;
            oe_next = ~rb.rdata[7];
            bit_next = 4'h1;
            st_next = lsadc_pkg::BS_RBYTE;
          end
        end
        default: st_next = lsadc_pkg::BS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= lsadc_pkg::BS_IDLE;
      sh_reg <= 8'h00;
      wd_reg <= 8'h00;
      bit_reg <= 4'h0;
      ptr_reg <= 3'h0;
      rw_reg <= 1'b0;
      first_reg <= 1'b0;
      oe_reg <= 1'b0;
      wr_reg <= 1'b0;
      rs_reg <= 1'b0;
      ci_reg <= 1'b0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      sh_reg <= sh_next;
      wd_reg <= wd_next;
      bit_reg <= bit_next;
      ptr_reg <= ptr_next;
      rw_reg <= rw_next;
      first_reg <= first_next;
      oe_reg <= oe_next;
      wr_reg <= wr_next;
      rs_reg <= rs_next;
      ci_reg <= ci_next;
      scl_d_reg <= scl;
      sda_d_reg <= sda;
    end
  end

  assign sda_oe = oe_reg;
  assign rb.addr = ptr_reg;
  assign rb.wr = wr_reg;
  assign rb.wdata = wd_reg;
  assign rb.restart = rs_reg;
  assign rb.clr_int = ci_reg;
endmodule
`default_nettype wire

/* File: include/lsadc_map.svh */
`ifndef LSADC_MAP_SVH
`define LSADC_MAP_SVH
// Operation
// - command bit 7 low holds converter in reset
// - command bit 6 high selects power-down
// - internal timing ends after programmed oscillator cycles
// - host timing spans between consecutive restart strobes
// - bits 3:2 pick diode one, two, difference, none
// - bits 1:0 pick 65536, 4096, 256, 16 cycles
// - control bit 5 shows interrupt triggered
// - writing zero clears flag until next trigger
// - control bits 3:2 pick range constant
// - flag after m consecutive out-of-window readings
// - upper threshold resets ff, low byte zero
// - lower threshold resets zero, low byte zero
// - reading bytes at 04 and 05, refreshed
// - timer counts oscillator cycles, latched at 06/07
// - timer meaningful only in host timing
// - address bit 7 write restarts integration
// - address bit 6 write clears interrupt
// - answer only to target address 1000100

`define LSADC_ADDR_CMD 3'h0
`define LSADC_ADDR_CTL 3'h1
`define LSADC_ADDR_THR_HI 3'h2
`define LSADC_ADDR_THR_LO 3'h3
`define LSADC_ADDR_RD_LO 3'h4
`define LSADC_ADDR_RD_HI 3'h5
`define LSADC_ADDR_TM_LO 3'h6
`define LSADC_ADDR_TM_HI 3'h7

`define LSADC_CMD_EN 7
`define LSADC_CMD_PD 6
`define LSADC_CMD_EXT 5
`define LSADC_CMD_RSVD 4
`define LSADC_CMD_MODE 2
`define LSADC_CMD_WIDTH 0
`define LSADC_CTL_FLAG 5
`define LSADC_CTL_GAIN 2
`define LSADC_CTL_PERS 0
`define LSADC_PTR_RESTART 7
`define LSADC_PTR_CLRINT 6

`define LSADC_CMD_RST 8'h00
`define LSADC_CTL_RST 4'h0
`define LSADC_THR_HI_RST 8'hff
`define LSADC_THR_LO_RST 8'h00

`define LSADC_SLAVE_ADDR 7'h44

`define LSADC_MODE_D1 2'h0
`define LSADC_MODE_D2 2'h1
`define LSADC_MODE_DIFF 2'h2
`define LSADC_MODE_NOP 2'h3

// last oscillator cycle index per width code
`define LSADC_LAST_W0 16'hffff
`define LSADC_LAST_W1 16'h0fff
`define LSADC_LAST_W2 16'h00ff
`define LSADC_LAST_W3 16'h000f

`define LSADC_PERS_0 5'h01
`define LSADC_PERS_1 5'h04
`define LSADC_PERS_2 5'h08
`define LSADC_PERS_3 5'h10

`define LSADC_RANGE_1 16'h03cd
`define LSADC_RANGE_2 16'h0f34
`define LSADC_RANGE_3 16'h3cd0
`define LSADC_RANGE_4 16'hf340
`endif

/* File: include/lsadc_pkg.sv */
package lsadc_pkg;
  typedef enum logic [2:0] {
    BS_IDLE, BS_ADDR, BS_AACK, BS_WBYTE, BS_WACK, BS_RBYTE, BS_RACK
  } lsadc_bus_st_t;
  typedef enum logic [1:0] {IS_RESET, IS_WAIT, IS_RUN} lsadc_int_st_t;
endpackage

/* File: include/lsadc_reg_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface lsadc_reg_if;
  logic [2:0] addr;
  logic       wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       restart;
  logic       clr_int;
  modport bus  (output addr, wr, wdata, restart, clr_int, input rdata);
  modport regs (input addr, wr, wdata, restart, clr_int, output rdata);
endinterface
`default_nettype wire
